/* File: core/eid_pkg.sv */
`default_nettype none
package eid_pkg;

	// =========================================================
	// Register map (word index, byte address is four times it)
	// =========================================================
	localparam int          EID_ADDR_W      = 12;
	localparam logic [7:0]  EID_CTRL_IDX    = 8'h7F;
	localparam logic [7:0]  EID_STAT_IDX    = 8'h80;
	localparam logic [7:0]  EID_MASK_IDX    = 8'h81;

	// =========================================================
	// Control/status field positions and reset values
	// =========================================================
	localparam int          EID_B_MODE      = 0;
	localparam int          EID_B_IE        = 1;
	localparam int          EID_B_ACK       = 2;
	localparam int          EID_B_FLAG      = 3;
	localparam int          EID_B_PE        = 4;
	localparam int          EID_B_EDG       = 5;
	localparam int          EID_B_PDD       = 6;
	localparam logic [7:0]  EID_CTRL_RST    = 8'h00;

	// Sticky status / mask layout
	localparam int          EID_S_EVENT     = 0;
	localparam int          EID_S_BLOCKED   = 1;
	localparam int          EID_STAT_W      = 2;
	localparam logic [1:0]  EID_STAT_RST    = 2'h0;
	localparam logic [1:0]  EID_MASK_RST    = 2'h0;

	// Request line idles high after reset
	localparam logic        EID_REQ_IDLE    = 1'b1;

	// AXI responses
	localparam logic [1:0]  EID_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  EID_RESP_DECERR = 2'h3;

	// Writable control fields
	typedef struct packed {
		logic pullDisable;
		logic polaritySelect;
		logic inputFunctionEnable;
		logic eventInterruptEnable;
		logic detectionMode;
	} eid_ctrl_t;

	localparam eid_ctrl_t   EID_CTRL_FIELDS_RST = '0;

endpackage
`default_nettype wire

/* File: core/eid_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module eid_sync (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic asyncIn,
	output logic      syncOut
);
	import eid_pkg::*;

	logic stage1_r;
	logic stage2_r;
	logic stage3_r;
	logic level_r;

	// Three flops, value accepted once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stage1_r <= EID_REQ_IDLE;
			stage2_r <= EID_REQ_IDLE;
			stage3_r <= EID_REQ_IDLE;
			level_r  <= EID_REQ_IDLE;
		end else begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			if (stage2_r == stage3_r) begin
				level_r <= stage3_r;
			end
		end
	end

	assign syncOut = level_r;

endmodule
`default_nettype wire

/* File: core/eid_top.sv */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Request honoured only while input function enabled
// - Polarity bit picks falling/low or rising/high
// - Mode bit picks edges only or edges+levels
// - Level mode: flag sets on assert edge
// - Level mode: flag held while level asserted
// - Event flag is read-only status bit
// - Acknowledge one clears flag, reads zero
// - Interrupt enable gates flag onto CPU interrupt
// - Pull disable bit effective only when enabled
// - Rising polarity forces pull device off
// - Bit seven reserved, reads zero
// - Synchronous sampling, asynchronous wake in stop
// - Eight-bit register, index 7F, resets zero
module eid_top (
	input  wire logic                          core_clk,
	input  wire logic                          rst_b,
	// AXI4-Lite slave
	input  wire logic [eid_pkg::EID_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [eid_pkg::EID_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Request line and system
	input  wire logic                          crossbarRequestOutput,
	input  wire logic                          stopMode,
	output logic                               cpuIrq,
	output logic                               pullEnable,
	output logic                               stopWake
);
	import eid_pkg::*;

	// =========================================================
	// Helpers
	// =========================================================
	function automatic logic addrHits(input logic [EID_ADDR_W-1:0] a, input logic [7:0] idx);
		addrHits = (a[EID_ADDR_W-1:2] == {2'h0, idx});
	endfunction

	// =========================================================
	// State
	// =========================================================
	eid_ctrl_t         ctrl_r;
	eid_ctrl_t         ctrl_nxt;
	logic              flag_r;
	logic              flag_nxt;
	logic [1:0]        stat_r;
	logic [1:0]        stat_nxt;
	logic [1:0]        mask_r;
	logic [1:0]        mask_nxt;
	logic              prevLevel_r;
	logic              reqLevel;
	logic              cpuIrq_r;
	logic              pullEnable_r;

	logic              awHave_r;
	logic              wHave_r;
	logic [EID_ADDR_W-1:0] awAddr_r;
	logic [31:0]       wData_r;
	logic [3:0]        wStrb_r;
	logic              awReady_r;
	logic              wReady_r;
	logic              bValid_r;
	logic [1:0]        bResp_r;
	logic              arReady_r;
	logic              rValid_r;
	logic [31:0]       rData_r;
	logic [1:0]        rResp_r;

	// =========================================================
	// Request synchroniser
	// =========================================================
	eid_sync u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.asyncIn  (crossbarRequestOutput),
		.syncOut  (reqLevel)
	);

	// =========================================================
	// Detection
	// =========================================================
	wire logic asserted    = ctrl_r.polaritySelect ? reqLevel : ~reqLevel;
	wire logic prevAsrt    = ctrl_r.polaritySelect ? prevLevel_r : ~prevLevel_r;
	wire logic assertEdge  = asserted & ~prevAsrt;
	wire logic levelHit    = ctrl_r.detectionMode & asserted;
	wire logic eventSet    = ctrl_r.inputFunctionEnable & (assertEdge | levelHit);

	// Previous synchronised level, idle high
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prevLevel_r <= EID_REQ_IDLE;
		end else begin
			prevLevel_r <= reqLevel;
		end
	end

	// =========================================================
	// Bus write path
	// =========================================================
	wire logic awFire   = s_axi_awvalid & awReady_r;
	wire logic wFire    = s_axi_wvalid & wReady_r;
	wire logic awAvail  = awHave_r | awFire;
	wire logic wAvail   = wHave_r | wFire;
	wire logic doWrite  = awAvail & wAvail & ~bValid_r;
	wire logic [EID_ADDR_W-1:0] wrAddr = awHave_r ? awAddr_r : s_axi_awaddr;
	wire logic [31:0]  wrData = wHave_r ? wData_r : s_axi_wdata;
	wire logic [3:0]   wrStrb = wHave_r ? wStrb_r : s_axi_wstrb;
	wire logic wrLane0  = doWrite & wrStrb[0];
	wire logic wrCtrl   = wrLane0 & addrHits(wrAddr, EID_CTRL_IDX);
	wire logic wrStat   = wrLane0 & addrHits(wrAddr, EID_STAT_IDX);
	wire logic wrMask   = wrLane0 & addrHits(wrAddr, EID_MASK_IDX);
	wire logic wrMapped = addrHits(wrAddr, EID_CTRL_IDX) | addrHits(wrAddr, EID_STAT_IDX)
		| addrHits(wrAddr, EID_MASK_IDX);
	wire logic ackWrite = wrCtrl & wrData[EID_B_ACK];
	wire logic bDone    = bValid_r & s_axi_bready;
	wire logic awHave_nxt = (awHave_r | awFire) & ~doWrite;
	wire logic wHave_nxt  = (wHave_r | wFire) & ~doWrite;
	wire logic bValid_nxt = doWrite | (bValid_r & ~s_axi_bready);

	// Write channel holding registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			awHave_r  <= 1'b0;
			wHave_r   <= 1'b0;
			awReady_r <= 1'b0;
			wReady_r  <= 1'b0;
			bValid_r  <= 1'b0;
			bResp_r   <= EID_RESP_OKAY;
		end else begin
			awHave_r  <= awHave_nxt;
			wHave_r   <= wHave_nxt;
			awReady_r <= ~awHave_nxt & ~bValid_nxt;
			wReady_r  <= ~wHave_nxt & ~bValid_nxt;
			bValid_r  <= bValid_nxt;
			if (doWrite) begin
				bResp_r <= wrMapped ? EID_RESP_OKAY : EID_RESP_DECERR;
			end
		end
	end

	// Captured address and data
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			awAddr_r <= '0;
			wData_r  <= 32'h0000_0000;
			wStrb_r  <= 4'h0;
		end else begin
			if (awFire) awAddr_r <= s_axi_awaddr;
			if (wFire) begin
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
		end
	end

	// =========================================================
	// Register updates
	// =========================================================
	// Control fields; flag and acknowledge bits not stored from writes
	assign ctrl_nxt = wrCtrl ? eid_ctrl_t'({wrData[EID_B_PDD], wrData[EID_B_EDG],
		wrData[EID_B_PE], wrData[EID_B_IE], wrData[EID_B_MODE]}) : ctrl_r;

	// Flag: set wins over acknowledge
	assign flag_nxt = eventSet | (flag_r & ~ackWrite);

	// Sticky status, write one to clear, set wins
	wire logic [1:0] statSet = {ackWrite & eventSet, eventSet};
	wire logic [1:0] statClr = wrStat ? wrData[EID_STAT_W-1:0] : 2'h0;
	assign stat_nxt = statSet | (stat_r & ~statClr);
	assign mask_nxt = wrMask ? wrData[EID_STAT_W-1:0] : mask_r;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctrl_r <= EID_CTRL_FIELDS_RST;
			flag_r <= EID_CTRL_RST[EID_B_FLAG];
			stat_r <= EID_STAT_RST;
			mask_r <= EID_MASK_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			flag_r <= flag_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
		end
	end

	// =========================================================
	// Outputs: interrupt and pull device
	// =========================================================
	wire logic irqNxt  = (ctrl_r.eventInterruptEnable & flag_r) | (|(stat_r & mask_r));
	wire logic pullNxt = ctrl_r.inputFunctionEnable & ~ctrl_r.pullDisable
		& ~ctrl_r.polaritySelect;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cpuIrq_r     <= 1'b0;
			pullEnable_r <= 1'b0;
		end else begin
			cpuIrq_r     <= irqNxt;
			pullEnable_r <= pullNxt;
		end
	end

	// Wake path bypasses the clock while it is stopped
	assign stopWake = stopMode & ctrl_r.inputFunctionEnable
		& (ctrl_r.polaritySelect ? crossbarRequestOutput : ~crossbarRequestOutput);

	// =========================================================
	// Bus read path
	// =========================================================
	wire logic arFire = s_axi_arvalid & arReady_r;
	wire logic [7:0] ctrlRead = {1'b0, ctrl_r.pullDisable, ctrl_r.polaritySelect,
		ctrl_r.inputFunctionEnable, flag_r, 1'b0, ctrl_r.eventInterruptEnable,
		ctrl_r.detectionMode};
	wire logic rdCtrl = addrHits(s_axi_araddr, EID_CTRL_IDX);
	wire logic rdStat = addrHits(s_axi_araddr, EID_STAT_IDX);
	wire logic rdMask = addrHits(s_axi_araddr, EID_MASK_IDX);
	wire logic [31:0] rdValue = rdCtrl ? {24'h00_0000, ctrlRead}
		: rdStat ? {30'h0000_0000, stat_r}
		: rdMask ? {30'h0000_0000, mask_r}
		: 32'h0000_0000;
	wire logic rValid_nxt = arFire | (rValid_r & ~s_axi_rready);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			arReady_r <= 1'b0;
			rValid_r  <= 1'b0;
			rData_r   <= 32'h0000_0000;
			rResp_r   <= EID_RESP_OKAY;
		end else begin
			arReady_r <= ~rValid_nxt;
			rValid_r  <= rValid_nxt;
			if (arFire) begin
				rData_r <= rdValue;
				rResp_r <= (rdCtrl | rdStat | rdMask) ? EID_RESP_OKAY : EID_RESP_DECERR;
			end
		end
	end

	assign s_axi_awready = awReady_r;
	assign s_axi_wready  = wReady_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;
	assign s_axi_arready = arReady_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rdata   = rData_r;
	assign s_axi_rresp   = rResp_r;
	assign cpuIrq        = cpuIrq_r;
	assign pullEnable    = pullEnable_r;

	// =========================================================
	// Checks
	// =========================================================
	property p_disabled_no_set;
		@(posedge core_clk) disable iff (!rst_b)
		(!ctrl_r.inputFunctionEnable && !flag_r) |=> !flag_r;
	endproperty
	a_disabled_no_set: assert property (p_disabled_no_set)
		else $error("flag set while input function disabled");

	property p_edge_sets;
		@(posedge core_clk) disable iff (!rst_b)
		(ctrl_r.inputFunctionEnable && assertEdge) |=> flag_r;
	endproperty
	a_edge_sets: assert property (p_edge_sets)
		else $error("asserting edge did not set flag");

	property p_edge_only_no_level;
		@(posedge core_clk) disable iff (!rst_b)
		(!ctrl_r.detectionMode && !assertEdge && ackWrite) |=> !flag_r;
	endproperty
	a_edge_only_no_level: assert property (p_edge_only_no_level)
		else $error("steady level held flag in edge-only mode");

	property p_level_holds;
		@(posedge core_clk) disable iff (!rst_b)
		(ctrl_r.inputFunctionEnable && ctrl_r.detectionMode && asserted) |=> flag_r;
	endproperty
	a_level_holds: assert property (p_level_holds)
		else $error("flag cleared while level asserted");

	property p_polarity;
		@(posedge core_clk) disable iff (!rst_b)
		(ctrl_r.inputFunctionEnable && ctrl_r.polaritySelect
			&& $rose(reqLevel) && !flag_r) |=> flag_r;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("rising edge missed with rising polarity");

	property p_irq_follows;
		@(posedge core_clk) disable iff (!rst_b)
		(ctrl_r.eventInterruptEnable && flag_r) |=> cpuIrq;
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("interrupt not raised for pending flag");

	property p_irq_quiet;
		@(posedge core_clk) disable iff (!rst_b)
		(!ctrl_r.eventInterruptEnable && ((stat_r & mask_r) == 2'h0)) |=> !cpuIrq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet)
		else $error("interrupt raised while disabled");

	property p_pull_rising_off;
		@(posedge core_clk) disable iff (!rst_b)
		(ctrl_r.inputFunctionEnable && ctrl_r.polaritySelect) |=> !pullEnable;
	endproperty
	a_pull_rising_off: assert property (p_pull_rising_off)
		else $error("pull device on with rising polarity");

	property p_pull_disable;
		@(posedge core_clk) disable iff (!rst_b)
		(!ctrl_r.inputFunctionEnable || ctrl_r.pullDisable) |=> !pullEnable;
	endproperty
	a_pull_disable: assert property (p_pull_disable)
		else $error("pull device on while disabled");

	property p_reserved_zero;
		@(posedge core_clk) disable iff (!rst_b)
		rValid_r |-> (rData_r[7] == 1'b0) && (rData_r[EID_B_ACK] == 1'b0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved or acknowledge bit read as one");

	property p_reset_value;
		@(posedge core_clk)
		!rst_b |=> (ctrlRead == EID_CTRL_RST) && !cpuIrq_r;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("control register not zero after reset");

endmodule
`default_nettype wire

/* File: dv/eid_xbar_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eid_xbar_model (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic reqLevel,
	output logic      crossbarRequestOutput
);
	import eid_pkg::*;
	// Line parks high in reset, then follows the commanded level
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			crossbarRequestOutput <= EID_REQ_IDLE;
		end else begin
			crossbarRequestOutput <= reqLevel;
		end
	end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import eid_pkg::*;
	// ==========================================
	// Signals
	// ==========================================
	localparam logic [11:0] A_CTRL = {2'b00, EID_CTRL_IDX, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, EID_STAT_IDX, 2'b00};
	localparam logic [11:0] A_MASK = {2'b00, EID_MASK_IDX, 2'b00};
	localparam logic [11:0] A_NONE = 12'h300;
	logic		core_clk, rst_b, stopMode, reqLevel;
	logic [11:0]	s_axi_awaddr, s_axi_araddr;
	logic		s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0]	s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]	s_axi_wstrb;
	logic [1:0]	s_axi_bresp, s_axi_rresp, rs;
	logic		crossbarRequestOutput, cpuIrq, pullEnable, stopWake;
	int		failures, cmp_count;

	// Device and the crossbar output feeding it
	eid_top eid_top_inst (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crossbarRequestOutput,
		.stopMode, .cpuIrq, .pullEnable, .stopWake);
	eid_xbar_model eid_xbar_model_inst (.core_clk, .rst_b, .reqLevel, .crossbarRequestOutput);

	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ==========================================
	// Helpers
	// ==========================================
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(posedge core_clk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				b = 1'b1;
				rs = s_axi_bresp;
			end
		end
		s_axi_bready <= 1'b0;
	endtask
	// Read: address held until taken, data taken with rvalid
	task automatic rdw(input logic [11:0] a);
		logic ar;
		ar = 1'b1;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (ar && s_axi_arready === 1'b1) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		rdw(a);
		chk("rresp", rs, EID_RESP_OKAY);
		chk("rdata", rd, {24'h000000, e});
	endtask
	task automatic line(input logic v);
		reqLevel <= v;
		wt(8);
	endtask

	// ==========================================
	// Scenarios
	// ==========================================
	task automatic t_reg();
		rc(A_CTRL, EID_CTRL_RST);
		rc(A_STAT, 8'h00);
		rc(A_MASK, 8'h00);
		rdw(A_NONE);
		chk("rresp", rs, EID_RESP_DECERR);
		chk("rdata", rd, 32'h0000_0000);
		wr(A_NONE, 8'hFF);
		chk("bresp", rs, EID_RESP_DECERR);
		wr(A_CTRL, 8'hCF);
		rc(A_CTRL, 8'h43);
		wr(A_CTRL, 8'h10);
		wt(2);
		chk("pull", pullEnable, 1);
		wr(A_CTRL, 8'h50);
		wt(2);
		chk("pull", pullEnable, 0);
		wr(A_CTRL, 8'h30);
		wt(2);
		chk("pull", pullEnable, 0);
	endtask
	task automatic t_edge();
		wr(A_CTRL, 8'h14);
		wt(6);
		wr(A_CTRL, 8'h14);
		rc(A_CTRL, 8'h10);
		line(1'b0);
		rc(A_CTRL, 8'h18);
		chk("irq", cpuIrq, 0);
		wr(A_CTRL, 8'h16);
		wt(8);
		rc(A_CTRL, 8'h12);
		chk("irq", cpuIrq, 0);
		line(1'b1);
	endtask
	task automatic t_off();
		wr(A_CTRL, 8'h00);
		stopMode <= 1'b1;
		line(1'b0);
		rc(A_CTRL, 8'h00);
		chk("wake", stopWake, 0);
		chk("pull", pullEnable, 0);
		stopMode <= 1'b0;
		line(1'b1);
	endtask
	task automatic t_level();
		wr(A_CTRL, 8'h13);
		wt(8);
		rc(A_CTRL, 8'h13);
		line(1'b0);
		rc(A_CTRL, 8'h1B);
		chk("irq", cpuIrq, 1);
		wr(A_CTRL, 8'h17);
		rc(A_CTRL, 8'h1B);
		chk("wake", stopWake, 0);
		stopMode <= 1'b1;
		wt(2);
		chk("wake", stopWake, 1);
		stopMode <= 1'b0;
		line(1'b1);
		wr(A_CTRL, 8'h17);
		rc(A_CTRL, 8'h13);
		wt(2);
		chk("irq", cpuIrq, 0);
	endtask
	task automatic t_rise();
		wr(A_CTRL, 8'h34);
		wt(8);
		wr(A_CTRL, 8'h34);
		rc(A_CTRL, 8'h30);
		chk("pull", pullEnable, 0);
		line(1'b0);
		rc(A_CTRL, 8'h30);
		line(1'b1);
		rc(A_CTRL, 8'h38);
	endtask
	task automatic t_irq();
		wr(A_CTRL, 8'h14);
		wt(8);
		wr(A_CTRL, 8'h14);
		wr(A_STAT, 8'h03);
		wr(A_MASK, 8'h01);
		rc(A_MASK, 8'h01);
		wt(2);
		chk("irq", cpuIrq, 0);
		line(1'b0);
		chk("irq", cpuIrq, 1);
		rc(A_STAT, 8'h01);
		wr(A_MASK, 8'h00);
		wt(2);
		chk("irq", cpuIrq, 0);
		wr(A_MASK, 8'h01);
		wt(2);
		chk("irq", cpuIrq, 1);
		wr(A_STAT, 8'h01);
		wt(2);
		chk("irq", cpuIrq, 0);
		rc(A_STAT, 8'h00);
		line(1'b1);
	endtask

	// ==========================================
	// Run control
	// ==========================================
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{stopMode, rst_b} = 2'b00;
		reqLevel = 1'b1;
		failures = 0;
		cmp_count = 0;
		wt(5);
		rst_b <= 1'b1;
		wt(1);
		t_reg();
		t_edge();
		t_off();
		t_level();
		t_rise();
		t_irq();
		tally_and_finish();
	end
	// Watchdog against a hung handshake
	initial begin
		wt(20000);
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
